/* hw/dam_pkg.sv */
// Package: constants and carriers of the data address mode decoder
package dam_pkg;

  // ***********************************************
  // Widths
  // ***********************************************
  localparam int ADDR_W    = 12;
  localparam int PROG_W    = 20;
  localparam int PTR_COUNT = 3;

  // ***********************************************
  // Special register addresses
  // ***********************************************
  localparam logic [11:0] IND_BASE      = 12'hFEF;  // Plain indirect operand of pointer 0
  localparam logic [11:0] IND_STRIDE    = 12'h008;  // Pointer n operand block at base - n*8
  localparam logic [11:0] PTR_LO_BASE   = 12'hFE9;  // Pointer 0 low byte
  localparam logic [11:0] PTR_HI_BASE   = 12'hFEA;  // Pointer 0 high byte
  localparam logic [11:0] BANK_REG_ADDR = 12'hFE0;  // Bank select register
  localparam logic [7:0]  ACCESS_SPLIT  = 8'h80;    // Access bank low/high split
  localparam logic [3:0]  SFR_BANK      = 4'hF;     // Bank of the special registers

  // ***********************************************
  // Reset values
  // ***********************************************
  localparam logic [11:0] PTR_RESET  = 12'h000;
  localparam logic [3:0]  BANK_RESET = 4'h0;

  // ***********************************************
  // Types
  // ***********************************************
  typedef enum logic [2:0] {
    DAM_INHERENT = 3'b000,
    DAM_LITERAL  = 3'b001,
    DAM_DIRECT   = 3'b010,
    DAM_FULL     = 3'b011,
    DAM_INDIRECT = 3'b100,
    DAM_INDEXED  = 3'b101
  } dam_mode_t;

  typedef enum logic [2:0] {
    DAM_IND_PLAIN   = 3'b000,
    DAM_IND_POSTINC = 3'b001,
    DAM_IND_POSTDEC = 3'b010,
    DAM_IND_PREINC  = 3'b011,
    DAM_IND_PLUSW   = 3'b100,
    DAM_IND_NONE    = 3'b111
  } dam_ind_t;

  typedef enum logic [1:0] {
    DAM_DST_NONE = 2'b00,
    DAM_DST_WREG = 2'b01,
    DAM_DST_FILE = 2'b10
  } dam_dst_t;

  // Decode request from the instruction stage
  typedef struct packed {
    logic        valid;
    dam_mode_t   mode;
    logic        access_sel;
    logic        has_dst;
    logic        dst_sel;
    logic        implicit_file;
    logic [7:0]  literal;
    logic [11:0] full_addr;
    logic [19:0] prog_addr;
  } dam_req_t;

  // Decoded answer to the data memory
  typedef struct packed {
    logic        valid;
    logic [11:0] addr;
    dam_dst_t    dst;
    logic [7:0]  literal;
    logic [19:0] prog_addr;
    logic        uses_addr;
  } dam_rsp_t;

endpackage : dam_pkg

/* hw/dam_ptr.sv */
// One file pointer register with direct write and post-access update
`timescale 1ns/1ps
module dam_ptr #(
  parameter int unsigned           IDX  = 0,
  parameter logic [11:0]           INIT = dam_pkg::PTR_RESET
) (
  // Clock and reset
  input  wire logic                mclk_in,
  input  wire logic                rst_in,
  // Direct write of the pointer bytes
  input  wire logic                wr_lo_in,
  input  wire logic                wr_hi_in,
  input  wire logic [7:0]          wr_data_in,
  // Update after an indirect access
  input  wire logic                upd_in,
  input  wire logic [11:0]         upd_value_in,
  // Current pointer
  output logic      [11:0]         ptr_out
);

  typedef struct packed {
    logic [11:0] ptr;
  } dam_ptr_state_t;

  dam_ptr_state_t st;
  dam_ptr_state_t next_st;

  // ***********************************************
  // Next state
  // ***********************************************
  always_comb begin
    next_st = st;
    if (upd_in) begin
      next_st.ptr = upd_value_in;  // see [RULE12]
    end else begin
      if (wr_lo_in) begin
        next_st.ptr[7:0] = wr_data_in;  // see [RULE11]
      end
      if (wr_hi_in) begin
        next_st.ptr[11:8] = wr_data_in[3:0];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st <= '{ptr: INIT};
    end else begin
      st <= next_st;
    end
  end

  assign ptr_out = st.ptr;

  ptr_update_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    upd_in |=> ptr_out == $past(upd_value_in))  // see [RULE14]
    else $error("pointer update not applied");

endmodule : dam_ptr

/* hw/dam_bank.sv */
// Bank select register, written directly by instructions
`timescale 1ns/1ps
module dam_bank (
  // Clock and reset
  input  wire logic                mclk_in,
  input  wire logic                rst_in,
  // Write port
  input  wire logic                wr_in,
  input  wire logic [7:0]          wr_data_in,
  // Current bank
  output logic      [3:0]          bank_out
);

  typedef struct packed {
    logic [3:0] bank;
  } dam_bank_state_t;

  dam_bank_state_t st;
  dam_bank_state_t next_st;

  always_comb begin
    next_st = st;
    if (wr_in) begin
      next_st.bank = wr_data_in[3:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st <= '{bank: dam_pkg::BANK_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign bank_out = st.bank;

endmodule : dam_bank

/* hw/dam_decoder.sv */
// Data address mode decoder: operand address and destination
`timescale 1ns/1ps
// Operation
// [RULE1] Mode fixed per instruction, up to three
// [RULE2] Indexed mode only with extended set on
// [RULE3] Inherent instructions need no address field
// [RULE4] Literal from opcode; 20-bit program address
// [RULE5] Byte and bit instructions use direct
// [RULE6] Access bit one: bank plus byte
// [RULE7] Access bit zero: access bank, bank ignored
// [RULE8] Full 12-bit address ignores bank register
// [RULE9] Destination bit: one file, zero working
// [RULE10] No destination bit: implicit fixed destination
// [RULE11] Indirect address from directly writable pointer
// [RULE12] Operand picks post-inc, post-dec or offset
// [RULE13] Bank low nibble gives bits 11:8
// [RULE14] Pointer update after access, old value used; pre-increment addresses the incremented value instead
module dam_decoder #(
  parameter int unsigned           NPTR = dam_pkg::PTR_COUNT
) (
  // Clock and reset
  input  wire logic                mclk_in,
  input  wire logic                rst_in,
  // Configuration
  input  wire logic                extended_set_enable_in,
  // Decode request
  input  wire dam_pkg::dam_req_t   req_in,
  input  wire logic [7:0]          wreg_in,
  // Data memory write seen by the special registers
  input  wire logic                mem_wr_in,
  input  wire logic [11:0]         mem_wr_addr_in,
  input  wire logic [7:0]          mem_wr_data_in,
  // Decoded answer
  output dam_pkg::dam_rsp_t        rsp_out,
  output dam_pkg::dam_mode_t       mode_out,
  output logic                     mode_err_out
);

  // ***********************************************
  // State
  // ***********************************************
  typedef struct packed {
    dam_pkg::dam_rsp_t  rsp;
    dam_pkg::dam_mode_t mode;
    logic               err;
  } dam_dec_state_t;

  dam_dec_state_t st;
  dam_dec_state_t next_st;

  logic [3:0]                bank;
  logic [NPTR-1:0][11:0]     ptr;
  logic [NPTR-1:0]           ptr_wr_lo;
  logic [NPTR-1:0]           ptr_wr_hi;
  logic [NPTR-1:0]           ptr_upd;
  logic [11:0]               upd_value;
  logic [11:0]               dir_addr;
  logic [11:0]               ind_addr;
  logic [11:0]               eff_addr;
  logic                      ind_hit;
  logic [1:0]                ind_sel;
  dam_pkg::dam_ind_t         ind_kind;
  logic                      bank_wr;

  // ***********************************************
  // Bank register and pointers
  // ***********************************************
  assign bank_wr = mem_wr_in && (mem_wr_addr_in == dam_pkg::BANK_REG_ADDR);

  dam_bank u_bank (
    .mclk_in    (mclk_in),
    .rst_in     (rst_in),
    .wr_in      (bank_wr),
    .wr_data_in (mem_wr_data_in),
    .bank_out   (bank)
  );

  generate
    for (genvar g = 0; g < NPTR; g++) begin : g_ptr
      localparam logic [11:0] OFS = 12'(g) * dam_pkg::IND_STRIDE;
      assign ptr_wr_lo[g] = mem_wr_in
                          && (mem_wr_addr_in == dam_pkg::PTR_LO_BASE - OFS);  // see [RULE11]
      assign ptr_wr_hi[g] = mem_wr_in
                          && (mem_wr_addr_in == dam_pkg::PTR_HI_BASE - OFS);
      dam_ptr #(
        .IDX (g)
      ) u_ptr (
        .mclk_in      (mclk_in),
        .rst_in       (rst_in),
        .wr_lo_in     (ptr_wr_lo[g]),
        .wr_hi_in     (ptr_wr_hi[g]),
        .wr_data_in   (mem_wr_data_in),
        .upd_in       (ptr_upd[g]),
        .upd_value_in (upd_value),
        .ptr_out      (ptr[g])
      );
    end
  endgenerate

  // ***********************************************
  // Direct address
  // ***********************************************
  always_comb begin
    if (req_in.access_sel) begin
      dir_addr = {bank, req_in.literal};  // see [RULE6] see [RULE13]
    end else if (req_in.literal < dam_pkg::ACCESS_SPLIT) begin
      dir_addr = {4'h0, req_in.literal};  // see [RULE7]
    end else begin
      dir_addr = {dam_pkg::SFR_BANK, req_in.literal};  // see [RULE7]
    end
  end

  // ***********************************************
  // Indirect operand detection
  // ***********************************************
  always_comb begin
    logic [11:0] diff;
    diff     = 12'h000;
    ind_hit  = 1'b0;
    ind_sel  = 2'd0;
    ind_kind = dam_pkg::DAM_IND_NONE;
    for (int i = 0; i < NPTR; i++) begin
      diff = dam_pkg::IND_BASE - 12'(i) * dam_pkg::IND_STRIDE - dir_addr;
      if (!ind_hit && diff < 12'h005) begin
        ind_hit  = 1'b1;
        ind_sel  = 2'(i);
        ind_kind = dam_pkg::dam_ind_t'(diff[2:0]);
      end
    end
  end

  // ***********************************************
  // Effective address and pointer update
  // ***********************************************
  always_comb begin
    ind_addr  = ptr[ind_sel];
    upd_value = ptr[ind_sel];
    ptr_upd   = '0;
    case (ind_kind)
      dam_pkg::DAM_IND_PREINC: ind_addr = ptr[ind_sel] + 12'h001;
      dam_pkg::DAM_IND_PLUSW:  ind_addr = ptr[ind_sel] + {{4{wreg_in[7]}}, wreg_in};  // see [RULE12]
      default:                 ind_addr = ptr[ind_sel];  // see [RULE14]
    endcase
    case (ind_kind)
      dam_pkg::DAM_IND_POSTINC: upd_value = ptr[ind_sel] + 12'h001;  // see [RULE12]
      dam_pkg::DAM_IND_POSTDEC: upd_value = ptr[ind_sel] - 12'h001;  // see [RULE12]
      dam_pkg::DAM_IND_PREINC:  upd_value = ptr[ind_sel] + 12'h001;
      default:                  upd_value = ptr[ind_sel];
    endcase
    if (req_in.valid && ind_hit && (req_in.mode == dam_pkg::DAM_DIRECT
        || req_in.mode == dam_pkg::DAM_INDIRECT)
        && ind_kind != dam_pkg::DAM_IND_PLAIN && ind_kind != dam_pkg::DAM_IND_PLUSW) begin
      ptr_upd[ind_sel] = 1'b1;  // see [RULE14]
    end
  end

  // ***********************************************
  // Mode decode
  // ***********************************************
  always_comb begin
    next_st                = st;
    next_st.rsp.valid      = req_in.valid;
    next_st.rsp.literal    = req_in.literal;
    next_st.rsp.prog_addr  = req_in.prog_addr;
    next_st.rsp.addr       = 12'h000;
    next_st.rsp.uses_addr  = 1'b0;
    next_st.rsp.dst        = dam_pkg::DAM_DST_NONE;
    next_st.err            = 1'b0;
    eff_addr               = ind_hit ? ind_addr : dir_addr;
    if (req_in.valid) begin
      next_st.mode = req_in.mode;  // see [RULE1]
      case (req_in.mode)
        dam_pkg::DAM_INHERENT: begin
          next_st.rsp.dst = req_in.implicit_file ? dam_pkg::DAM_DST_FILE
                                                 : dam_pkg::DAM_DST_NONE;  // see [RULE3]
        end
        dam_pkg::DAM_LITERAL: begin
          next_st.rsp.dst = dam_pkg::DAM_DST_WREG;  // see [RULE4]
        end
        dam_pkg::DAM_DIRECT, dam_pkg::DAM_INDIRECT: begin
          next_st.rsp.addr      = eff_addr;  // see [RULE5] see [RULE11]
          next_st.rsp.uses_addr = 1'b1;
        end
        dam_pkg::DAM_FULL: begin
          next_st.rsp.addr      = req_in.full_addr;  // see [RULE8]
          next_st.rsp.uses_addr = 1'b1;
        end
        dam_pkg::DAM_INDEXED: begin
          if (extended_set_enable_in) begin
            next_st.rsp.addr      = ptr[2] + {4'h0, req_in.literal};  // see [RULE2]
            next_st.rsp.uses_addr = 1'b1;
          end else begin
            next_st.err = 1'b1;  // see [RULE2]
          end
        end
        default: begin
          next_st.err = 1'b1;
        end
      endcase
      if (next_st.rsp.uses_addr) begin
        if (req_in.has_dst) begin
          next_st.rsp.dst = req_in.dst_sel ? dam_pkg::DAM_DST_FILE
                                           : dam_pkg::DAM_DST_WREG;  // see [RULE9]
        end else begin
          next_st.rsp.dst = req_in.implicit_file ? dam_pkg::DAM_DST_FILE
                                                 : dam_pkg::DAM_DST_WREG;  // see [RULE10]
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rsp_out      = st.rsp;
  assign mode_out     = st.mode;
  assign mode_err_out = st.err;

  // ***********************************************
  // Checks
  // ***********************************************
  sequence s_direct_banked;
    req_in.valid && req_in.mode == dam_pkg::DAM_DIRECT && req_in.access_sel && !ind_hit;
  endsequence

  bank_direct_a: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [RULE6]
    s_direct_banked |=> rsp_out.addr == {$past(bank), $past(req_in.literal)})
    else $error("banked address wrong");
  access_bank_a: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [RULE7]
    req_in.valid && req_in.mode == dam_pkg::DAM_DIRECT && !req_in.access_sel && !ind_hit
    |=> rsp_out.addr[7:0] == $past(req_in.literal)
        && (rsp_out.addr[11:8] == 4'h0 || rsp_out.addr[11:8] == 4'hF))
    else $error("access bank address wrong");
  full_addr_a: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [RULE8]
    req_in.valid && req_in.mode == dam_pkg::DAM_FULL |=> rsp_out.addr == $past(req_in.full_addr))
    else $error("full address altered");
  dst_select_a: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [RULE9]
    req_in.valid && req_in.mode == dam_pkg::DAM_DIRECT && req_in.has_dst
    |=> rsp_out.dst == ($past(req_in.dst_sel) ? dam_pkg::DAM_DST_FILE : dam_pkg::DAM_DST_WREG))
    else $error("destination select wrong");
  dst_implicit_a: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [RULE10]
    req_in.valid && req_in.mode == dam_pkg::DAM_FULL && !req_in.has_dst && req_in.implicit_file
    |=> rsp_out.dst == dam_pkg::DAM_DST_FILE)
    else $error("implicit destination wrong");
  indexed_gate_a: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [RULE2]
    req_in.valid && req_in.mode == dam_pkg::DAM_INDEXED |=> mode_err_out == !$past(extended_set_enable_in))
    else $error("indexed mode gating wrong");
  inherent_noaddr_a: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [RULE3]
    req_in.valid && req_in.mode == dam_pkg::DAM_INHERENT |=> !rsp_out.uses_addr)
    else $error("inherent used an address");
  literal_pass_a: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [RULE4]
    req_in.valid && req_in.mode == dam_pkg::DAM_LITERAL
    |=> rsp_out.prog_addr == $past(req_in.prog_addr) && rsp_out.dst == dam_pkg::DAM_DST_WREG)
    else $error("literal not passed");
  postinc_a: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [RULE12]
    ptr_upd[0] && ind_kind == dam_pkg::DAM_IND_POSTINC && !ptr_wr_lo[0] && !ptr_wr_hi[0]
    |=> rsp_out.addr == $past(ptr[0]) && ptr[0] == $past(ptr[0]) + 12'h001)
    else $error("post increment wrong");

  // ***********************************************
  // Pointer, register and mode checks
  // ***********************************************
  sequence s_ind_ptr0;
    req_in.valid && ind_hit && ind_sel == 2'd0 && !ptr_wr_lo[0] && !ptr_wr_hi[0]
    && (req_in.mode == dam_pkg::DAM_DIRECT || req_in.mode == dam_pkg::DAM_INDIRECT);
  endsequence

  post_dec_a: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [RULE12]
    s_ind_ptr0 ##0 (ind_kind == dam_pkg::DAM_IND_POSTDEC)
    |=> rsp_out.addr == $past(ptr[0]) && ptr[0] == $past(ptr[0]) - 12'h001)
    else $error("post decrement wrong");

  plain_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [RULE14]
    s_ind_ptr0 ##0 (ind_kind == dam_pkg::DAM_IND_PLAIN)
    |=> rsp_out.addr == $past(ptr[0]) && ptr[0] == $past(ptr[0]))
    else $error("plain operand moved pointer");

  plusw_addr_a: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [RULE12]
    s_ind_ptr0 ##0 (ind_kind == dam_pkg::DAM_IND_PLUSW)
    |=> rsp_out.addr == $past(ptr[0]) + {{4{$past(wreg_in[7])}}, $past(wreg_in)}
        && ptr[0] == $past(ptr[0]))
    else $error("offset operand wrong");

  ptr_write_a: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [RULE11]
    ptr_wr_lo[0] && !ptr_upd[0] |=> ptr[0][7:0] == $past(mem_wr_data_in))
    else $error("pointer byte write lost");

  bank_write_a: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [RULE13]
    bank_wr |=> bank == $past(mem_wr_data_in[3:0]))
    else $error("bank write lost");

  direct_addr_a: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [RULE5]
    req_in.valid && req_in.mode == dam_pkg::DAM_DIRECT |=> rsp_out.valid && rsp_out.uses_addr)
    else $error("direct access without address");

  mode_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [RULE1]
    !req_in.valid |=> $stable(mode_out) && !rsp_out.valid)
    else $error("mode changed while idle");

  mode_err_a: assert property (@(posedge mclk_in) disable iff (rst_in)  // see [RULE1]
    req_in.valid && req_in.mode[2:1] == 2'b11
    |=> mode_err_out && !rsp_out.uses_addr && rsp_out.dst == dam_pkg::DAM_DST_NONE)
    else $error("unknown mode not flagged");

endmodule : dam_decoder

/* sim/dam_mem_model.sv */
// Partner model: banked data memory and special registers seen by the decoder
`timescale 1ns/1ps
module dam_mem_model (
  // Clock
  input  wire logic              mclk_in,
  // Decoded answer
  input  wire dam_pkg::dam_rsp_t rsp_in,
  // Special register writes
  output logic                   mem_wr_out,
  output logic      [11:0]       mem_wr_addr_out,
  output logic      [7:0]        mem_wr_data_out
);
  // ***********************************************
  // Storage
  // ***********************************************
  logic [11:0] last_addr;

  initial begin
    mem_wr_out      = 1'b0;
    mem_wr_addr_out = 12'h000;
    mem_wr_data_out = 8'h00;
    last_addr       = 12'h000;
  end

  // Tracks the location that each answer with uses_addr set reaches
  always @(posedge mclk_in) begin
    if (rsp_in.valid && rsp_in.uses_addr) begin
      last_addr <= rsp_in.addr;
    end
  end

  // ***********************************************
  // One write to a mapped register
  // ***********************************************
  task automatic store(input logic [11:0] addr, input logic [7:0] data);
    @(negedge mclk_in);
    mem_wr_out      = 1'b1;
    mem_wr_addr_out = addr;
    mem_wr_data_out = data;
    @(negedge mclk_in);
    mem_wr_out      = 1'b0;
    mem_wr_addr_out = ~addr;  // Released bus shows no stale value
    mem_wr_data_out = ~data;
  endtask : store
endmodule : dam_mem_model

/* sim/dam_decoder_bench.sv */
// Testbench of the data address mode decoder
`timescale 1ns/1ps
module dam_decoder_bench;
  // ***********************************************
  // Signals
  // ***********************************************
  logic               mclk_in;
  logic               rst_in;
  logic               extended_set_enable_in;
  dam_pkg::dam_req_t  req_in;
  logic [7:0]         wreg_in;
  logic               mem_wr_in;
  logic [11:0]        mem_wr_addr_in;
  logic [7:0]         mem_wr_data_in;
  dam_pkg::dam_rsp_t  rsp_out;
  dam_pkg::dam_mode_t mode_out;
  logic               mode_err_out;
  int                 errors;
  int                 n_tests;

  dam_decoder dam_decoder_inst (
    .mclk_in(mclk_in), .rst_in(rst_in), .extended_set_enable_in(extended_set_enable_in),
    .req_in(req_in), .wreg_in(wreg_in), .mem_wr_in(mem_wr_in),
    .mem_wr_addr_in(mem_wr_addr_in), .mem_wr_data_in(mem_wr_data_in),
    .rsp_out(rsp_out), .mode_out(mode_out), .mode_err_out(mode_err_out));

  dam_mem_model dam_mem_model_inst (
    .mclk_in(mclk_in), .rsp_in(rsp_out), .mem_wr_out(mem_wr_in),
    .mem_wr_addr_out(mem_wr_addr_in), .mem_wr_data_out(mem_wr_data_in));

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // ***********************************************
  // Shared tasks
  // ***********************************************
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // Presents one request at a falling edge, returns when the answer stands
  task automatic send(input dam_pkg::dam_mode_t m, input logic a, input logic [2:0] dfl,
                      input logic [7:0] lit, input logic [11:0] full, input logic [19:0] prog);
    req_in.valid         = 1'b1;
    req_in.mode          = m;
    req_in.access_sel    = a;
    req_in.has_dst       = dfl[2];
    req_in.dst_sel       = dfl[1];
    req_in.implicit_file = dfl[0];
    req_in.literal       = lit;
    req_in.full_addr     = full;
    req_in.prog_addr     = prog;
    @(negedge mclk_in);
    check({47'h0, rsp_out.valid}, 48'h0000_0000_0001);
  endtask : send

  task automatic dir(input logic a, input logic [2:0] dfl, input logic [7:0] lit);
    send(dam_pkg::DAM_DIRECT, a, dfl, lit, 12'h000, 20'h0_0000);
  endtask : dir

  task automatic idle;
    req_in.valid = 1'b0;
    @(negedge mclk_in);
  endtask : idle

  // ***********************************************
  // Scenarios
  // ***********************************************
  task automatic t_reset(input int cycles);
    rst_in = 1'b1;
    repeat (cycles) @(negedge mclk_in);
    rst_in = 1'b0;
    check({4'h0, rsp_out}, 48'h0000_0000_0000);
    check({44'h0, mode_out, mode_err_out}, 48'h0000_0000_0000);
    dir(1'b1, 3'b000, 8'h34);
    check({36'h0, rsp_out.addr}, 48'h0000_0000_0034);
    dir(1'b0, 3'b000, 8'hEF);
    check({36'h0, rsp_out.addr}, 48'h0000_0000_0000);
    idle();
  endtask : t_reset

  task automatic t_direct;
    dam_mem_model_inst.store(dam_pkg::BANK_REG_ADDR, 8'h05);
    dir(1'b1, 3'b110, 8'h34);
    check({36'h0, rsp_out.addr}, 48'h0000_0000_0534);
    check({47'h0, rsp_out.uses_addr}, 48'h0000_0000_0001);
    check({46'h0, rsp_out.dst}, {46'h0, dam_pkg::DAM_DST_FILE});
    dir(1'b1, 3'b100, 8'hC7);
    check({36'h0, rsp_out.addr}, 48'h0000_0000_05C7);
    check({46'h0, rsp_out.dst}, {46'h0, dam_pkg::DAM_DST_WREG});
    dir(1'b0, 3'b001, 8'h34);
    check({36'h0, rsp_out.addr}, 48'h0000_0000_0034);
    check({46'h0, rsp_out.dst}, {46'h0, dam_pkg::DAM_DST_FILE});
    dir(1'b0, 3'b000, 8'h90);
    check({36'h0, rsp_out.addr}, 48'h0000_0000_0F90);
    check({46'h0, rsp_out.dst}, {46'h0, dam_pkg::DAM_DST_WREG});
    send(dam_pkg::DAM_FULL, 1'b1, 3'b000, 8'h12, 12'hABC, 20'h0_0000);
    check({36'h0, rsp_out.addr}, 48'h0000_0000_0ABC);
    idle();
  endtask : t_direct

  task automatic t_inherent_literal;
    send(dam_pkg::DAM_INHERENT, 1'b0, 3'b000, 8'h00, 12'h000, 20'h0_0000);
    check({47'h0, rsp_out.uses_addr}, 48'h0000_0000_0000);
    check({45'h0, mode_out}, {45'h0, dam_pkg::DAM_INHERENT});
    send(dam_pkg::DAM_INHERENT, 1'b0, 3'b001, 8'h00, 12'h000, 20'h0_0000);
    check({46'h0, rsp_out.dst}, {46'h0, dam_pkg::DAM_DST_FILE});
    send(dam_pkg::DAM_LITERAL, 1'b0, 3'b000, 8'hA5, 12'h000, 20'hF_2345);
    check({40'h0, rsp_out.literal}, 48'h0000_0000_00A5);
    check({28'h0, rsp_out.prog_addr}, 48'h0000_000F_2345);
    check({45'h0, mode_out}, {45'h0, dam_pkg::DAM_LITERAL});
    idle();
    check({45'h0, mode_out}, {45'h0, dam_pkg::DAM_LITERAL});
    send(dam_pkg::dam_mode_t'(3'b110), 1'b0, 3'b000, 8'h00, 12'h000, 20'h0_0000);
    check({47'h0, mode_err_out}, 48'h0000_0000_0001);
    check({47'h0, rsp_out.uses_addr}, 48'h0000_0000_0000);
    idle();
  endtask : t_inherent_literal

  task automatic t_indexed;
    extended_set_enable_in = 1'b0;
    send(dam_pkg::DAM_INDEXED, 1'b0, 3'b000, 8'h05, 12'h000, 20'h0_0000);
    check({47'h0, mode_err_out}, 48'h0000_0000_0001);
    check({47'h0, rsp_out.uses_addr}, 48'h0000_0000_0000);
    idle();
    dam_mem_model_inst.store(12'hFD9, 8'h20);
    dam_mem_model_inst.store(12'hFDA, 8'h03);
    extended_set_enable_in = 1'b1;
    send(dam_pkg::DAM_INDEXED, 1'b0, 3'b000, 8'h05, 12'h000, 20'h0_0000);
    check({47'h0, mode_err_out}, 48'h0000_0000_0000);
    check({36'h0, rsp_out.addr}, 48'h0000_0000_0325);
    idle();
  endtask : t_indexed

  task automatic t_indirect;
    dam_mem_model_inst.store(12'hFE9, 8'h00);
    dam_mem_model_inst.store(12'hFEA, 8'h01);
    wreg_in = 8'h10;
    dir(1'b0, 3'b110, 8'hEE);
    check({36'h0, rsp_out.addr}, 48'h0000_0000_0100);
    dir(1'b0, 3'b110, 8'hEE);
    check({36'h0, rsp_out.addr}, 48'h0000_0000_0101);
    dir(1'b0, 3'b110, 8'hED);
    check({36'h0, rsp_out.addr}, 48'h0000_0000_0102);
    dir(1'b0, 3'b110, 8'hEF);
    check({36'h0, rsp_out.addr}, 48'h0000_0000_0101);
    dir(1'b0, 3'b110, 8'hEB);
    check({36'h0, rsp_out.addr}, 48'h0000_0000_0111);
    dir(1'b0, 3'b110, 8'hEF);
    check({36'h0, rsp_out.addr}, 48'h0000_0000_0101);
    dir(1'b0, 3'b110, 8'hEC);
    check({36'h0, rsp_out.addr}, 48'h0000_0000_0102);
    send(dam_pkg::DAM_INDIRECT, 1'b0, 3'b110, 8'hEF, 12'h000, 20'h0_0000);
    check({36'h0, rsp_out.addr}, 48'h0000_0000_0102);
    dam_mem_model_inst.store(12'hFE1, 8'h40);
    dir(1'b0, 3'b110, 8'hE6);
    check({36'h0, rsp_out.addr}, 48'h0000_0000_0040);
    dir(1'b0, 3'b110, 8'hE7);
    check({36'h0, rsp_out.addr}, 48'h0000_0000_0041);
    idle();
    check({36'h0, dam_mem_model_inst.last_addr}, 48'h0000_0000_0041);
  endtask : t_indirect

  // ***********************************************
  // Main sequence and watchdog
  // ***********************************************
  initial begin
    errors                 = 0;
    n_tests                = 0;
    extended_set_enable_in = 1'b0;
    req_in                 = '0;
    wreg_in                = 8'h00;
    t_reset(3);
    t_direct();
    t_inherent_literal();
    t_indexed();
    t_indirect();
    t_reset(2);
    end_of_test();
  end

  initial begin
    repeat (2000) @(posedge mclk_in);
    errors++;
    end_of_test();
  end
endmodule : dam_decoder_bench
